// File: ast_defs.svh
// Constants for the converter status and test logic
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH
`define AST_OFF_STATUS 4'h0
`define AST_OFF_TEST0 4'h4
`define AST_OFF_TEST1 4'h8
`define AST_BIT_SEQ_DONE 7
`define AST_BIT_TRIG_OVR 5
`define AST_BIT_RES_OVW 4
`define AST_BIT_SPC_EN 0
`define AST_CNT_ZERO 3'h0
`define AST_CNT_ONE 3'h1
`define AST_SEL_HIGH 3'h4
`define AST_SEL_LOW 3'h5
`define AST_SEL_MID 3'h6
`define AST_RESP_OKAY 2'h0
`define AST_RESP_SLVERR 2'h2
`define AST_TEST0_READ 8'hA5
`endif

// File: ast_pkg.sv
// Types of the converter status and test logic
package ast_pkg;
  typedef enum logic [1:0] {
    AST_SPC_NONE = 2'h0,
    AST_SPC_HIGH = 2'h1,
    AST_SPC_LOW = 2'h3,
    AST_SPC_MID = 2'h2
  } ast_spc_t;
endpackage

// File: ast_status.sv
// Converter status flags, conversion counter and special channel test logic
`timescale 1ns/100ps
`default_nettype none
`include "ast_defs.svh"
module ast_status (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic special_mode,
  input wire logic repeat_mode,
  input wire logic ring_mode,
  input wire logic fast_flag_clear,
  input wire logic trigger_level_select,
  input wire logic seq_begin,
  input wire logic seq_end,
  input wire logic conv_done,
  input wire logic trigger_edge,
  input wire logic trigger_start,
  input wire logic start_write,
  input wire logic ctl234_write,
  input wire logic ctl_write,
  input wire logic result_read,
  input wire logic conversion_done_flag,
  input wire logic [2:0] channel_select,
  output logic seq_active,
  output logic [2:0] conversion_counter,
  output logic special_channel_enable,
  output logic [1:0] special_channel,
  output logic [7:0] test0_out
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic [3:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic active;
    logic sequence_done_flag;
    logic trigger_overrun_flag;
    logic result_overwrite_flag;
    logic [2:0] cnt;
    logic [7:0] test1;
    logic [7:0] test0;
    ast_pkg::ast_spc_t spc;
  } ast_state_t;

  ast_state_t st_r;
  ast_state_t st_nxt;

  function automatic logic ast_hit(input logic [3:0] a, input logic [3:0] off);
    ast_hit = (a[3:2] == off[3:2]);
  endfunction

  logic wr_fire;
  logic wr_lane0;
  logic [7:0] status_rd;
  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign wr_lane0 = wr_fire && st_r.wstrb[0];
  assign status_rd = {st_r.sequence_done_flag, 1'b0, st_r.trigger_overrun_flag,
                      st_r.result_overwrite_flag, 1'b0, st_r.cnt};

  always_comb
  begin
    logic stat_wr;
    logic new_start;
    stat_wr = 1'b0;
    new_start = 1'b0;
    st_nxt = st_r;
    // Write address and data accepted in either order, one write at a time
    if (s_axi_awvalid && !st_r.aw_got)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `AST_RESP_OKAY;
      if (ast_hit(st_r.awaddr, `AST_OFF_STATUS))
        stat_wr = wr_lane0;
      else if (ast_hit(st_r.awaddr, `AST_OFF_TEST0))
      begin
        if (wr_lane0 && special_mode)
          st_nxt.test0 = st_r.wdata[7:0];
      end
      else if (ast_hit(st_r.awaddr, `AST_OFF_TEST1))
      begin
        if (wr_lane0)
          st_nxt.test1 = st_r.wdata[7:0];
      end
      else
        st_nxt.bresp = `AST_RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    if (s_axi_arvalid && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `AST_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (ast_hit(s_axi_araddr, `AST_OFF_STATUS))
        st_nxt.rdata[7:0] = status_rd;
      else if (ast_hit(s_axi_araddr, `AST_OFF_TEST0))
        st_nxt.rdata[7:0] = `AST_TEST0_READ;
      else if (ast_hit(s_axi_araddr, `AST_OFF_TEST1))
        st_nxt.rdata[7:0] = st_r.test1;
      else
        st_nxt.rresp = `AST_RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;

    new_start = start_write || trigger_start;
    if (seq_begin || new_start)
      st_nxt.active = 1'b1;
    if (seq_end || ctl234_write)
      st_nxt.active = 1'b0;

    // Clears first, then sets, so a same-cycle event is kept
    if ((stat_wr && st_r.wdata[`AST_BIT_SEQ_DONE]) || start_write
        || (fast_flag_clear && result_read))
      st_nxt.sequence_done_flag = 1'b0;
    if (seq_end)
      st_nxt.sequence_done_flag = 1'b1;
    if ((stat_wr && st_r.wdata[`AST_BIT_TRIG_OVR]) || ctl234_write || start_write)
      st_nxt.trigger_overrun_flag = 1'b0;
    if (!trigger_level_select && trigger_edge && st_r.active)
      st_nxt.trigger_overrun_flag = 1'b1;
    if ((stat_wr && st_r.wdata[`AST_BIT_RES_OVW]) || new_start)
      st_nxt.result_overwrite_flag = 1'b0;
    if (conv_done && conversion_done_flag)
      st_nxt.result_overwrite_flag = 1'b1;

    // Counter is never touched by the status write path
    if (conv_done)
      st_nxt.cnt = st_r.cnt + `AST_CNT_ONE;
    if (!ring_mode && (seq_begin || seq_end))
      st_nxt.cnt = `AST_CNT_ZERO;
    if (ctl_write || ctl234_write)
      st_nxt.cnt = `AST_CNT_ZERO;

    st_nxt.spc = ast_pkg::AST_SPC_NONE;
    if (st_r.test1[`AST_BIT_SPC_EN])
    begin
      unique case (channel_select)
        `AST_SEL_HIGH: st_nxt.spc = ast_pkg::AST_SPC_HIGH;
        `AST_SEL_LOW: st_nxt.spc = ast_pkg::AST_SPC_LOW;
        `AST_SEL_MID: st_nxt.spc = ast_pkg::AST_SPC_MID;
        default: st_nxt.spc = ast_pkg::AST_SPC_NONE;
      endcase
    end

    // Readies are flops of their own so every bus output leaves a register
    st_nxt.awready = !st_nxt.aw_got;
    st_nxt.wready = !st_nxt.w_got;
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign seq_active = st_r.active;
  assign conversion_counter = st_r.cnt;
  assign special_channel_enable = st_r.test1[`AST_BIT_SPC_EN];
  assign special_channel = st_r.spc;
  assign test0_out = st_r.test0;

  // Each clear check holds its competing set off, since a set wins the cycle
  a_seq_done_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seq_end
    |=> st_r.sequence_done_flag)
    else $error("sequence done flag not set");

  a_repeat_done: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (repeat_mode && seq_end)
    |=> st_r.sequence_done_flag)
    else $error("sequence done flag not set in repeat operation");

  a_seq_done_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!seq_end && !st_r.sequence_done_flag)
    |=> !st_r.sequence_done_flag)
    else $error("sequence done flag set without a sequence end");

  a_seq_done_clr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (start_write && !seq_end)
    |=> !st_r.sequence_done_flag)
    else $error("sequence done flag not cleared");

  a_fast_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (fast_flag_clear && result_read && !seq_end)
    |=> !st_r.sequence_done_flag)
    else $error("sequence done flag not cleared by result read");

  a_overrun_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!trigger_level_select && trigger_edge && seq_active)
    |=> st_r.trigger_overrun_flag)
    else $error("overrun flag not set");

  a_overrun_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (trigger_level_select && !st_r.trigger_overrun_flag)
    |=> !st_r.trigger_overrun_flag)
    else $error("overrun flag set in level trigger operation");

  a_overrun_clr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ctl234_write && !trigger_edge)
    |=> !st_r.trigger_overrun_flag)
    else $error("overrun flag not cleared");

  a_overrun_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (start_write && !trigger_edge)
    |=> !st_r.trigger_overrun_flag)
    else $error("overrun flag not cleared by a sequence start");

  a_overwrite_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (conv_done && conversion_done_flag)
    |=> st_r.result_overwrite_flag)
    else $error("overwrite flag not set");

  a_overwrite_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!conv_done && !st_r.result_overwrite_flag)
    |=> !st_r.result_overwrite_flag)
    else $error("overwrite flag set without a result write");

  a_overwrite_clr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (trigger_start && !conv_done)
    |=> !st_r.result_overwrite_flag)
    else $error("overwrite flag not cleared");

  a_overwrite_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (start_write && !conv_done)
    |=> !st_r.result_overwrite_flag)
    else $error("overwrite flag not cleared by a start write");

  a_count_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (conv_done && ring_mode && !ctl_write && !ctl234_write)
    |=> conversion_counter == $past(conversion_counter) + `AST_CNT_ONE)
    else $error("counter did not step");

  a_count_ring: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ring_mode && (seq_begin || seq_end) && !conv_done && !ctl_write && !ctl234_write)
    |=> $stable(conversion_counter))
    else $error("counter reinitialised in ring operation");

  a_count_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!ring_mode && seq_end)
    |=> conversion_counter == `AST_CNT_ZERO)
    else $error("counter not zeroed");

  a_count_begin: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!ring_mode && seq_begin)
    |=> conversion_counter == `AST_CNT_ZERO)
    else $error("counter not zeroed at sequence begin");

  a_count_abort: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctl234_write
    |=> conversion_counter == `AST_CNT_ZERO)
    else $error("counter not cleared on abort");

  a_count_ctl: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctl_write
    |=> conversion_counter == `AST_CNT_ZERO)
    else $error("counter not cleared on control write");

  a_count_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!conv_done && !seq_begin && !seq_end && !ctl_write && !ctl234_write)
    |=> $stable(conversion_counter))
    else $error("counter changed without a counter event");

  a_spc_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (special_channel_enable && channel_select == `AST_SEL_HIGH)
    |=> special_channel == ast_pkg::AST_SPC_HIGH)
    else $error("high reference not chosen");

  a_spc_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (special_channel_enable && channel_select == `AST_SEL_LOW)
    |=> special_channel == ast_pkg::AST_SPC_LOW)
    else $error("low reference not chosen");

  a_spc_mid: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (special_channel_enable && channel_select == `AST_SEL_MID)
    |=> special_channel == ast_pkg::AST_SPC_MID)
    else $error("reference midpoint not chosen");

  a_spc_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !special_channel_enable
    |=> special_channel == ast_pkg::AST_SPC_NONE)
    else $error("special channel chosen while disabled");

  a_test0_guard: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !special_mode
    |=> $stable(test0_out))
    else $error("reserved test register changed in normal mode");

  a_flags_reset: assert property (@(posedge sys_clk)
    sys_rst
    |=> (!st_r.sequence_done_flag && !st_r.trigger_overrun_flag
      && !st_r.result_overwrite_flag && !special_channel_enable
      && conversion_counter == `AST_CNT_ZERO))
    else $error("state not cleared by reset");

  a_write_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.aw_got && st_r.w_got && !s_axi_bvalid)
    |=> s_axi_bvalid)
    else $error("write response missing");

  a_read_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_axi_arvalid && s_axi_arready)
    |=> s_axi_rvalid)
    else $error("read response missing");
endmodule // ast_status
`default_nettype wire

// File: ast_testbench.sv
// Self-checking testbench for the converter status and test logic
`timescale 1ns/100ps
`default_nettype none
`include "ast_defs.svh"
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'h0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrd, bv, arr, rv, act, spe;
  logic [31:0] wd = 32'h0, rdt;
  logic [1:0] br, rr, spc, wresp;
  logic smode = 1'b0, ring = 1'b0, ffc = 1'b0, tls = 1'b0, cdf = 1'b0, rpt = 1'b0;
  logic [2:0] csel = 3'h0, cnt;
  logic [7:0] t0, p;
  // Pulse bits: begin,end,conv,edge,trig start,start wr,ctl234,ctl wr,result rd
  logic [8:0] evs = 9'h000;
  int mismatches = 0, total_checks = 0, cyc = 0;
  ast_status u_dut (
    .sys_clk(clk), .sys_rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .special_mode(smode),
    .repeat_mode(rpt), .ring_mode(ring), .fast_flag_clear(ffc),
    .trigger_level_select(tls), .seq_begin(evs[8]), .seq_end(evs[7]), .conv_done(evs[6]),
    .trigger_edge(evs[5]), .trigger_start(evs[4]), .start_write(evs[3]),
    .ctl234_write(evs[2]), .ctl_write(evs[1]), .result_read(evs[0]),
    .conversion_done_flag(cdf), .channel_select(csel), .seq_active(act),
    .conversion_counter(cnt), .special_channel_enable(spe), .special_channel(spc),
    .test0_out(t0));
  always #5 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Cuts a hung handshake short; the whole run needs well under 2000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
      $display("FAIL %0t got %h expected %h", $time, g, e);
    if (g !== e)
      mismatches++;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {awa, wd, ws, awv, wv, bry} <= {a, 24'h0, d, 4'hF, 3'h7};
    while (1)
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv)
      begin
        wresp = br;
        bry <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'h3};
    while (1)
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv)
      begin
        {d, r} = {rdt[7:0], rr};
        rry <= 1'b0;
        break;
      end
    end
  endtask
  // Reads a register and compares the bits under the mask
  task automatic st(input logic [7:0] e, input logic [7:0] m = 8'hFF, input logic [3:0] a = 4'h0);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, e);
  endtask
  // One-cycle event pulse; returns once its effect has landed
  task automatic ev(input logic [8:0] m, input int n = 1);
    repeat (n)
    begin
      @(posedge clk);
      evs <= m;
      @(posedge clk);
      evs <= 9'h000;
      @(posedge clk);
    end
  endtask
  task automatic t_flags;
    st(8'h00);
    ev(9'h100);
    ev(9'h040, 2);
    wr(`AST_OFF_STATUS, 8'hFF);
    st(8'h02);
    ev(9'h080);
    st(8'h80);
    ffc <= 1'b1;
    ev(9'h001);
    st(8'h00, 8'h80);
    ev(9'h180);
    wr(`AST_OFF_STATUS, 8'h80);
    st(8'h00, 8'h80);
    ev(9'h100);
    chk(act, 8'h01);
    ev(9'h020);
    st(8'h20);
    ev(9'h004);
    chk(act, 8'h00);
    st(8'h00, 8'h20);
    ev(9'h180);
    ev(9'h008);
    st(8'h00, 8'h80);
    cdf <= 1'b1;
    ev(9'h100);
    ev(9'h040);
    st(8'h11);
    ev(9'h010);
    st(8'h00, 8'h10);
    cdf <= 1'b0;
    tls <= 1'b1;
    ev(9'h100);
    ev(9'h060);
    st(8'h00, 8'h30);
  endtask
  task automatic t_ring;
    ring <= 1'b1;
    ev(9'h002);
    chk(cnt, `AST_CNT_ZERO);
    rpt <= 1'b1;
    ev(9'h040, 9);
    ev(9'h080);
    st(8'h80, 8'h80);
    wr(`AST_OFF_STATUS, 8'h80);
    ev(9'h080);
    st(8'h80, 8'h80);
    ev(9'h100);
    chk(cnt, `AST_CNT_ONE);
    ev(9'h004);
    chk(cnt, `AST_CNT_ZERO);
  endtask
  task automatic t_test;
    logic [1:0] e;
    logic [1:0] r;
    wr(`AST_OFF_TEST1, 8'h01);
    chk(spe, 8'h01);
    chk(wresp, `AST_RESP_OKAY);
    st(8'h01, 8'h3F, `AST_OFF_TEST1);
    for (int i = 0; i < 8; i++)
    begin
      csel <= i[2:0];
      e = (i == 4) ? ast_pkg::AST_SPC_HIGH : (i == 5) ? ast_pkg::AST_SPC_LOW : 2'h0;
      e = (i == 6) ? ast_pkg::AST_SPC_MID : e;
      ev(9'h000);
      chk(spc, e);
    end
    p = t0;
    wr(`AST_OFF_TEST0, 8'h3C);
    chk(t0, p);
    smode <= 1'b1;
    wr(`AST_OFF_TEST0, 8'h3C);
    chk(t0, 8'h3C);
    rd(4'hC, p, r);
    chk(r, `AST_RESP_SLVERR);
    wr(4'hC, 8'h00);
    chk(wresp, `AST_RESP_SLVERR);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_flags();
    t_ring();
    t_test();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
